// File: inc/ppsm_params.svh
`ifndef PPSM_PARAMS_SVH
`define PPSM_PARAMS_SVH

// ==========================================================
// Parameter list
`define PPSM_NPARAM 64
`define PPSM_IDX_LAST 6'h3f
`define PPSM_MOTOR_IDX 6'h02
`define PPSM_SPEED_OFS_IDX 6'h2f
`define PPSM_TORQUE_OFS_IDX 6'h36

// ==========================================================
// Menus and function codes
`define PPSM_MGMT_LAST 6'h02
`define PPSM_ZERO_LAST 6'h01
`define PPSM_FN_LAST 6'h3f
`define PPSM_FN_ENC_RESET 6'h24
`define PPSM_FN_ENC_CLEAR 6'h25
`define PPSM_ENC_CMD_RESET 2'h1
`define PPSM_ENC_CMD_CLEAR 2'h2

// ==========================================================
// Timing
`define PPSM_HOLD_MS 3000
`define PPSM_CLK_KHZ 100000
`define PPSM_HOLD_CYCLES ((`PPSM_HOLD_MS) * (`PPSM_CLK_KHZ))
`define PPSM_ZERO_CNT_LAST 4'hf

// ==========================================================
// Register map
`define PPSM_REG_STATUS 12'h000
`define PPSM_REG_CTRL 12'h004
`define PPSM_REG_PARAM_PAGE 4'h1
`define PPSM_CTRL_RST 2'h0

`endif

// File: inc/ppsm_pkg.sv
package ppsm_pkg;
  typedef enum logic [2:0] {
    ST_COPY,
    ST_SELECT,
    ST_ZERO,
    ST_ZERO_WR,
    ST_DONE
  } ppsm_state_e;
  typedef enum logic [1:0] {
    OP_SAVE,
    OP_LOAD,
    OP_DEFAULT
  } ppsm_op_e;
  typedef enum logic [1:0] {
    MODE_MGMT,
    MODE_SPECIAL,
    MODE_ZERO
  } ppsm_mode_e;
endpackage

// File: design/ppsm_key_hold.sv
module ppsm_key_hold #(
  parameter logic [28:0] HOLD_CYCLES = 29'h0000_0010
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic key_in,
  input wire logic enable_in,
  output logic fire_out,
  output logic abort_out
);
  logic [28:0] cnt;
  logic fired;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt <= 29'h0;
      fired <= 1'b0;
      fire_out <= 1'b0;
      abort_out <= 1'b0;
    end else begin
      fire_out <= 1'b0;
      abort_out <= 1'b0;
      if (!key_in || !enable_in) begin
        abort_out <= (cnt != 29'h0) && !fired;
        cnt <= 29'h0;
        fired <= 1'b0;
      end else if (!fired) begin
        if (cnt == HOLD_CYCLES) begin
          fire_out <= 1'b1;
          fired <= 1'b1;
        end else begin
          cnt <= cnt + 29'h1;
        end
      end
    end
  end
endmodule // ppsm_key_hold

// File: design/ppsm_top.sv
`include "ppsm_params.svh"

module ppsm_top #(
  parameter int unsigned HOLD_CYCLES = `PPSM_HOLD_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic key_up_in,
  input wire logic key_down_in,
  input wire logic key_confirm_in,
  input wire logic key_exit_in,
  output logic ee_req_out,
  output logic ee_we_out,
  output logic [5:0] ee_addr_out,
  output logic [15:0] ee_wdata_out,
  input wire logic [15:0] ee_rdata_in,
  input wire logic ee_ack_in,
  input wire logic enc_multiturn_in,
  output logic enc_cmd_valid_out,
  output logic [1:0] enc_cmd_out,
  input wire logic [15:0] adc_speed_in,
  input wire logic [15:0] adc_torque_in,
  output logic busy_out
);
  import ppsm_pkg::*;

  // ==========================================================
  // Functions
  function automatic logic [5:0] step_sel(input logic [5:0] s, input logic up,
                                          input logic [5:0] last);
    if (up) begin
      step_sel = (s >= last) ? 6'h00 : s + 6'h01;
    end else begin
      step_sel = (s == 6'h00) ? last : s - 6'h01;
    end
  endfunction

  // Factory value depends on the motor code, which itself survives the restore
  function automatic logic [15:0] def_value(input logic [5:0] i, input logic [15:0] motor);
    def_value = (i == `PPSM_MOTOR_IDX) ? motor : {motor[7:0], 2'b00, i};
  endfunction

  // ==========================================================
  // State
  logic [15:0] work [0:`PPSM_NPARAM-1];
  ppsm_state_e state, next_state;
  ppsm_op_e op;
  ppsm_mode_e mode;
  logic [5:0] sel;
  logic [5:0] idx;
  logic boot;
  logic err;
  logic [3:0] zcnt;
  logic signed [19:0] acc;
  logic up_q, down_q, exit_q;
  logic wr_pend;
  logic [11:0] wr_addr;
  logic hold_fire, hold_abort;

  wire up_press = key_up_in & ~up_q;
  wire down_press = key_down_in & ~down_q;
  wire exit_press = key_exit_in & ~exit_q;
  wire ack_ok = ee_req_out & ee_ack_in;
  wire copy_last = ack_ok && (idx == `PPSM_IDX_LAST);
  wire [5:0] sel_last = (mode == MODE_MGMT) ? `PPSM_MGMT_LAST :
                        (mode == MODE_ZERO) ? `PPSM_ZERO_LAST : `PPSM_FN_LAST;
  wire [5:0] zidx = sel[0] ? `PPSM_TORQUE_OFS_IDX : `PPSM_SPEED_OFS_IDX;
  wire signed [15:0] zsample = sel[0] ? adc_torque_in : adc_speed_in;
  wire signed [19:0] zsum = acc + 20'(zsample);
  wire [15:0] def_now = def_value(idx, work[`PPSM_MOTOR_IDX]);
  wire idle = (state == ST_SELECT) || (state == ST_DONE);
  wire next_busy = (next_state != ST_SELECT) && (next_state != ST_DONE);

  ppsm_key_hold #(
    .HOLD_CYCLES(29'(HOLD_CYCLES))
  ) u_hold (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .key_in(key_confirm_in),
    .enable_in(state == ST_SELECT),
    .fire_out(hold_fire),
    .abort_out(hold_abort)
  );

  // ==========================================================
  // Bus slave
  wire addr_ok = hsel_in & htrans_in[1] & hready_in;
  wire hi_zero = (haddr_in[31:12] == 20'h00000);
  wire [31:0] status_word = {20'h00000, boot, err, state == ST_DONE, busy_out, mode, sel};
  wire [31:0] rd_word =
    !hi_zero ? 32'h0 :
    (haddr_in[11:0] == `PPSM_REG_STATUS) ? status_word :
    (haddr_in[11:0] == `PPSM_REG_CTRL) ? {30'h0, mode} :
    (haddr_in[11:8] == `PPSM_REG_PARAM_PAGE) ? {16'h0000, work[haddr_in[7:2]]} : 32'h0;
  wire wr_ctrl = wr_pend && (wr_addr == `PPSM_REG_CTRL);
  wire wr_param = wr_pend && (wr_addr[11:8] == `PPSM_REG_PARAM_PAGE);

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      hrdata_out <= 32'h0;
      hreadyout_out <= 1'b0;
      hresp_out <= 1'b0;
    end else begin
      wr_pend <= addr_ok & hwrite_in & hi_zero;
      wr_addr <= haddr_in[11:0];
      hreadyout_out <= 1'b1;
      if (addr_ok && !hwrite_in) begin
        hrdata_out <= rd_word;
      end
    end
  end

  // ==========================================================
  // Working list
  always_ff @(posedge ref_clk_in) begin
    if (state == ST_COPY && ack_ok && op == OP_LOAD) begin
      work[ee_addr_out] <= ee_rdata_in;
    end else if (state == ST_COPY && !ee_req_out && op == OP_DEFAULT) begin
      work[idx] <= def_now;
    end else if (state == ST_ZERO && zcnt == `PPSM_ZERO_CNT_LAST) begin
      work[zidx] <= zsum[19:4];
    end else if (wr_param && idle) begin
      work[wr_addr[7:2]] <= hwdata_in[15:0];
    end
  end

  // ==========================================================
  // Sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_COPY: begin
        if (copy_last) begin
          next_state = boot ? ST_SELECT : ST_DONE;
        end
      end
      ST_SELECT: begin
        if (hold_fire) begin
          next_state = (mode == MODE_MGMT) ? ST_COPY :
                       (mode == MODE_ZERO) ? ST_ZERO : ST_DONE;
        end
      end
      ST_ZERO: begin
        if (zcnt == `PPSM_ZERO_CNT_LAST) begin
          next_state = ST_ZERO_WR;
        end
      end
      ST_ZERO_WR: begin
        if (ack_ok) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (exit_press) begin
          next_state = ST_SELECT;
        end
      end
      default: next_state = ST_SELECT;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ST_COPY;
      op <= OP_LOAD;
      boot <= 1'b1;
      busy_out <= 1'b1;
      mode <= ppsm_mode_e'(`PPSM_CTRL_RST);
      sel <= 6'h00;
      idx <= 6'h00;
      err <= 1'b0;
      zcnt <= 4'h0;
      acc <= 20'sh0;
      up_q <= 1'b0;
      down_q <= 1'b0;
      exit_q <= 1'b0;
      ee_req_out <= 1'b0;
      ee_we_out <= 1'b0;
      ee_addr_out <= 6'h00;
      ee_wdata_out <= 16'h0000;
      enc_cmd_valid_out <= 1'b0;
      enc_cmd_out <= 2'h0;
    end else begin
      state <= next_state;
      busy_out <= next_busy;
      up_q <= key_up_in;
      down_q <= key_down_in;
      exit_q <= key_exit_in;
      enc_cmd_valid_out <= 1'b0;
      case (state)
        ST_SELECT: begin
          if (wr_ctrl && hwdata_in[1:0] <= 2'h2) begin
            mode <= ppsm_mode_e'(hwdata_in[1:0]);
            sel <= 6'h00;
          end else if (hold_fire) begin
            err <= 1'b0;
            idx <= 6'h00;
            zcnt <= 4'h0;
            acc <= 20'sh0;
            op <= ppsm_op_e'(sel[1:0]);
            if (mode == MODE_SPECIAL) begin
              if (sel == `PPSM_FN_ENC_RESET && enc_multiturn_in) begin
                enc_cmd_valid_out <= 1'b1;
                enc_cmd_out <= `PPSM_ENC_CMD_RESET;
              end else if (sel == `PPSM_FN_ENC_CLEAR) begin
                enc_cmd_valid_out <= 1'b1;
                enc_cmd_out <= `PPSM_ENC_CMD_CLEAR;
              end else begin
                err <= 1'b1;
              end
            end
          end else if (up_press || down_press) begin
            sel <= step_sel(sel, up_press, sel_last);
          end
        end
        ST_COPY: begin
          if (!ee_req_out) begin
            ee_req_out <= 1'b1;
            ee_we_out <= (op != OP_LOAD);
            ee_addr_out <= idx;
            ee_wdata_out <= (op == OP_DEFAULT) ? def_now : work[idx];
          end else if (ee_ack_in) begin
            ee_req_out <= 1'b0;
            ee_we_out <= 1'b0;
            idx <= idx + 6'h01;
            if (copy_last) begin
              boot <= 1'b0;
            end
          end
        end
        ST_ZERO: begin
          acc <= zsum;
          zcnt <= zcnt + 4'h1;
        end
        ST_ZERO_WR: begin
          if (!ee_req_out) begin
            ee_req_out <= 1'b1;
            ee_we_out <= 1'b1;
            ee_addr_out <= zidx;
            ee_wdata_out <= work[zidx];
          end else if (ee_ack_in) begin
            ee_req_out <= 1'b0;
            ee_we_out <= 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_sel_range;
    (mode == MODE_MGMT) |-> (sel <= `PPSM_MGMT_LAST);
  endproperty
  a_sel_range: assert property (p_sel_range) else $error("menu index out of range");
  property p_hold_gate;
    (state == ST_SELECT && !hold_fire) |=> (state == ST_SELECT);
  endproperty
  a_hold_gate: assert property (p_hold_gate) else $error("op began without hold");
  property p_exit;
    (state == ST_DONE && exit_press) |=> (state == ST_SELECT) && !busy_out;
  endproperty
  a_exit: assert property (p_exit) else $error("exit did not return");
  property p_save_data;
    (state == ST_COPY && op == OP_SAVE && ee_req_out)
      |-> ee_we_out && (ee_wdata_out == work[ee_addr_out]);
  endproperty
  a_save_data: assert property (p_save_data) else $error("save wrote wrong word");
  property p_ee_only_ops;
    ee_req_out |-> (state == ST_COPY || state == ST_ZERO_WR);
  endproperty
  a_ee_only_ops: assert property (p_ee_only_ops) else $error("stray EEPROM access");
  property p_load_word;
    (state == ST_COPY && op == OP_LOAD && ack_ok)
      ##1 1'b1 |-> (work[$past(ee_addr_out)] == $past(ee_rdata_in));
  endproperty
  a_load_word: assert property (p_load_word) else $error("reload word lost");
  property p_boot_first;
    (state == ST_SELECT) |-> !boot && (op == OP_LOAD || !$past(boot));
  endproperty
  a_boot_first: assert property (p_boot_first) else $error("boot load skipped");
  property p_default_data;
    (state == ST_COPY && op == OP_DEFAULT && ee_req_out)
      |-> ee_we_out && (ee_wdata_out == work[ee_addr_out]);
  endproperty
  a_default_data: assert property (p_default_data) else $error("default not mirrored");
  property p_enc_reset;
    (enc_cmd_valid_out && enc_cmd_out == `PPSM_ENC_CMD_RESET)
      |-> $past(hold_fire) && $past(sel) == `PPSM_FN_ENC_RESET && $past(enc_multiturn_in);
  endproperty
  a_enc_reset: assert property (p_enc_reset) else $error("bad encoder reset");
  property p_zero_commit;
    (state == ST_ZERO_WR && ee_req_out) |-> ee_we_out && (ee_addr_out == zidx);
  endproperty
  a_zero_commit: assert property (p_zero_commit) else $error("offset not committed");
  property p_abort;
    hold_abort |-> (state == ST_SELECT) ##1 (state == ST_SELECT) && !ee_req_out;
  endproperty
  a_abort: assert property (p_abort) else $error("aborted request ran");
  property p_busy_keys;
    (busy_out && (up_press || down_press)) |=> $stable(sel);
  endproperty
  a_busy_keys: assert property (p_busy_keys) else $error("key taken while busy");
  c_save: cover property (state == ST_COPY && op == OP_SAVE && copy_last);
  c_default: cover property (state == ST_COPY && op == OP_DEFAULT && copy_last);
  c_zero: cover property (state == ST_ZERO_WR && ack_ok);
  c_enc: cover property (enc_cmd_valid_out);
endmodule // ppsm_top

// File: verification/ppsm_ee_model.sv
module ppsm_ee_model (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic slow_in,
  input wire logic ee_req_in,
  input wire logic ee_we_in,
  input wire logic [5:0] ee_addr_in,
  input wire logic [15:0] ee_wdata_in,
  output logic [15:0] ee_rdata_out,
  output logic ee_ack_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [64];
  logic [2:0] wait_cnt;
  // ==========================================================
  // Stored image, kept across resets like a real part
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 16'h5a00 + 16'(i);
    end
  end
  // ==========================================================
  // Answer, promptly or after five idle cycles
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wait_cnt <= 3'h0;
      ee_ack_out <= 1'b0;
      ee_rdata_out <= 16'h0;
    end else if (ee_ack_out) begin
      wait_cnt <= 3'h0;
      ee_ack_out <= 1'b0;
      // Scrambled so nothing leans on data after the pulse
      ee_rdata_out <= ~ee_rdata_out;
    end else if (ee_req_in && (!slow_in || wait_cnt == 3'h5)) begin
      ee_ack_out <= 1'b1;
      ee_rdata_out <= mem[ee_addr_in];
      if (ee_we_in) begin
        mem[ee_addr_in] <= ee_wdata_in;
      end
    end else if (ee_req_in) begin
      wait_cnt <= wait_cnt + 3'h1;
    end
  end
endmodule // ppsm_ee_model

// File: verification/panel_parameter_store_manager_tb_top.sv
`include "ppsm_params.svh"

module panel_parameter_store_manager_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ppsm_pkg::*;
  localparam int unsigned HOLD = 8;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] keys = 4'h0;
  logic multi = 1'b1;
  logic slow = 1'b0;
  logic [15:0] adc_s = 16'h0;
  logic [15:0] adc_t = 16'h0;
  logic [31:0] hrdata;
  logic hrdy;
  logic hresp;
  logic busy;
  logic [15:0] ee_rdata;
  logic [15:0] ee_wdata;
  logic [5:0] ee_addr;
  logic ee_req;
  logic ee_we;
  logic ee_ack;
  logic enc_v;
  logic [1:0] enc_cmd;
  logic [1:0] enc_last = 2'h0;
  logic [31:0] rdv;
  int enc_pulses = 0;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  ppsm_top #(.HOLD_CYCLES(HOLD)) i_dut (.ref_clk_in(clk), .nrst_in(nrst), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
    .hresp_out(hresp), .key_up_in(keys[0]), .key_down_in(keys[1]), .key_confirm_in(keys[2]),
    .key_exit_in(keys[3]), .ee_req_out(ee_req), .ee_we_out(ee_we), .ee_addr_out(ee_addr),
    .ee_wdata_out(ee_wdata), .ee_rdata_in(ee_rdata), .ee_ack_in(ee_ack),
    .enc_multiturn_in(multi), .enc_cmd_valid_out(enc_v), .enc_cmd_out(enc_cmd),
    .adc_speed_in(adc_s), .adc_torque_in(adc_t), .busy_out(busy));

  ppsm_ee_model i_ee (.ref_clk_in(clk), .nrst_in(nrst), .slow_in(slow), .ee_req_in(ee_req),
    .ee_we_in(ee_we), .ee_addr_in(ee_addr), .ee_wdata_in(ee_wdata),
    .ee_rdata_out(ee_rdata), .ee_ack_out(ee_ack));

  // ==========================================================
  // Monitors and hang guard
  always @(posedge clk) begin
    if (enc_v === 1'b1) begin
      enc_pulses <= enc_pulses + 1;
      enc_last <= enc_cmd;
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Helpers
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk(32'(hresp), 32'h0);
    hsel <= 1'b0;
  endtask

  task automatic press(input int k, input int n);
    @(posedge clk);
    keys[k] <= 1'b1;
    repeat (n) @(posedge clk);
    keys[k] <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_st(input int b, input logic v);
    for (int n = 0; n < 1000; n++) begin
      ahb(1'b0, `PPSM_REG_STATUS, 32'h0, rdv);
      if (rdv[b] === v) break;
    end
    chk(32'(rdv[b]), 32'(v));
  endtask

  function automatic logic [11:0] pa(input int i);
    return 12'h100 + 12'(4 * i);
  endfunction

  // Expected list: 0 boot image, 1 after edit and save, 2 defaults
  function automatic logic [15:0] ev(input int i, input int k);
    if (k == 2) return (i == 2) ? 16'h00a7 : {8'ha7, 2'b00, 6'(i)};
    if (k == 1 && i == 3) return 16'h0c3c;
    return 16'h5a00 + 16'(i);
  endfunction

  task automatic cmp_all(input int k);
    for (int i = 0; i < 64; i++) begin
      ahb(1'b0, pa(i), 32'h0, rdv);
      chk(rdv, 32'(ev(i, k)));
      chk(32'(i_ee.mem[i]), 32'(ev(i, k)));
    end
  endtask

  // Select mode and entry, long-press confirm, poke a key while busy (modes 0, 2) or done (mode 1), exit
  task automatic op(input logic [1:0] m, input logic [5:0] t);
    ahb(1'b1, `PPSM_REG_CTRL, {30'h0, m}, rdv);
    for (int n = 0; n < 70; n++) begin
      ahb(1'b0, `PPSM_REG_STATUS, 32'h0, rdv);
      if (rdv[5:0] === t) break;
      press(0, 2);
    end
    press(2, HOLD + 3);
    chk(32'(busy), {31'h0, m != 2'h1});
    press(0, 2);
    wait_st(9, 1'b1);
    chk(32'(rdv[5:0]), 32'(t));
    press(3, 2);
    ahb(1'b0, `PPSM_REG_STATUS, 32'h0, rdv);
    chk(32'(rdv[9]), 32'h0);
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    wait_st(11, 1'b0);
    cmp_all(0);
    ahb(1'b0, 12'h200, 32'h0, rdv);
    chk(rdv, 32'h0);
    ahb(1'b1, `PPSM_REG_CTRL, 32'h3, rdv);
    ahb(1'b0, `PPSM_REG_CTRL, 32'h0, rdv);
    chk(rdv, 32'h0);
    $display("test boot done");
    for (int s = 1; s <= 3; s++) begin
      press(0, 2);
      ahb(1'b0, `PPSM_REG_STATUS, 32'h0, rdv);
      chk(rdv, 32'(s % 3));
    end
    press(1, 2);
    ahb(1'b0, `PPSM_REG_STATUS, 32'h0, rdv);
    chk(rdv, 32'h2);
    $display("test menu done");
    ahb(1'b1, pa(1), 32'hbeef, rdv);
    ahb(1'b0, pa(1), 32'h0, rdv);
    chk(rdv, 32'hbeef);
    chk(32'(i_ee.mem[1]), 32'h5a01);
    press(1, 2);
    press(2, HOLD - 2);
    repeat (20) @(posedge clk);
    ahb(1'b0, pa(1), 32'h0, rdv);
    chk(rdv, 32'hbeef);
    chk(32'(i_ee.mem[1]), 32'h5a01);
    op(2'h0, 6'h1);
    ahb(1'b0, pa(1), 32'h0, rdv);
    chk(rdv, 32'h5a01);
    $display("test reload done");
    ahb(1'b1, pa(3), 32'h0c3c, rdv);
    slow <= 1'b1;
    op(2'h0, 6'h0);
    slow <= 1'b0;
    cmp_all(1);
    $display("test save done");
    ahb(1'b1, pa(2), 32'h00a7, rdv);
    op(2'h0, 6'h2);
    cmp_all(2);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    wait_st(11, 1'b0);
    cmp_all(2);
    $display("test restore done");
    op(2'h1, 6'h24);
    chk(32'(enc_pulses), 32'h1);
    chk(32'(enc_last), 32'(`PPSM_ENC_CMD_RESET));
    op(2'h1, 6'h25);
    chk(32'(enc_pulses), 32'h2);
    chk(32'(enc_last), 32'(`PPSM_ENC_CMD_CLEAR));
    multi <= 1'b0;
    op(2'h1, 6'h24);
    chk(32'(rdv[10]), 32'h1);
    chk(32'(enc_pulses), 32'h2);
    $display("test encoder done");
    adc_s <= 16'h0123;
    op(2'h2, 6'h0);
    ahb(1'b0, pa(47), 32'h0, rdv);
    chk(rdv, 32'h0123);
    chk(32'(i_ee.mem[47]), 32'h0123);
    adc_t <= 16'hfff0;
    op(2'h2, 6'h1);
    ahb(1'b0, pa(54), 32'h0, rdv);
    chk(rdv, 32'hfff0);
    chk(32'(i_ee.mem[54]), 32'hfff0);
    $display("test zeroing done");
    report_and_stop();
  end
endmodule // panel_parameter_store_manager_tb_top
